/* fcs16.v */
// byte-wise 16-bit frame check sequence accumulator
// assumes bytes arrive lsb first on air, one per valid cycle
`timescale 1ns/1ps
`include "rx_filter_phy_consts.vh"

module fcs16 (
    input wire ref_clk,
    input wire nrst,
    input wire clear,
    input wire valid,
    input wire [7:0] data,
    output reg [15:0] crc
);

    function [15:0] fcs_step;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] t;
        begin
            t = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (t[0] ^ d[i]) begin
                    t = (t >> 1) ^ `FCS_POLY_REFLECTED;
                end else begin
                    t = t >> 1;
                end
            end
            fcs_step = t;
        end
    endfunction

    // clear has priority so a new frame never inherits the old sum
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            crc <= `FCS_INIT;
        end else if (clear) begin
            crc <= `FCS_INIT;
        end else if (valid) begin
            crc <= fcs_step(crc, data);
        end
    end

endmodule // fcs16

/* rx_filter_phy_config_regs.v */
// receive-filter and phy configuration registers with the logic they steer:
// transmit fcs append, receive acceptance, acknowledgement reply and cca compare
// assumes the radio datapath supplies byte streams and per-frame filter results
`timescale 1ns/1ps
`include "rx_filter_phy_consts.vh"

module rx_filter_phy_config_regs (
    input wire ref_clk,
    input wire nrst,
    input wire sck,
    input wire cs_n,
    input wire sdi,
    output wire sdo,
    output wire sdo_oe,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_last,
    output reg tx_ready,
    output reg [7:0] phy_tx_data,
    output reg phy_tx_valid,
    output reg phy_tx_last,
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_end,
    input wire rx_ack_request,
    input wire rx_mac_addr_mismatch,
    input wire rx_illegal_frame_type,
    input wire rx_pan_mismatch,
    input wire rx_short_addr_mismatch,
    output reg rx_frame_accept,
    output reg rx_frame_drop,
    output reg rx_crc_ok,
    output reg ack_send,
    input wire [7:0] cca_rssi,
    input wire cca_rssi_valid,
    output reg cca_done,
    output reg cca_fail,
    output reg synth_lock_enable,
    output reg [4:0] tx_attenuation_code,
    output reg tx_shaping_filter,
    output reg supply_monitor_on,
    output reg oscillator_boost,
    output reg refclk_early_stabilize,
    output reg network_leader_role,
    output reg parent_role
);

    localparam [2:0] ST_DATA = 3'b001;
    localparam [2:0] ST_FCS_LO = 3'b010;
    localparam [2:0] ST_FCS_HI = 3'b100;

    reg [7:0] receive_filter_control;
    reg [7:0] rf_pll_control;
    reg [7:0] tx_power_control;
    reg [7:0] tx_filter_battery_control;
    reg [7:0] vco_refclk_control;
    reg [7:0] cca_rssi_threshold;
    reg [7:0] rd_data;
    reg [2:0] tx_state;
    reg [2:0] next_tx_state;
    reg [15:0] fcs_hold;

    wire [5:0] reg_addr;
    wire [7:0] wr_data;
    wire wr_stb;
    wire [15:0] tx_crc;
    wire [15:0] rx_crc;
    wire tx_take;
    wire rx_fcs_good;
    wire filter_miss;
    wire rx_keep;

    spi_short_port u_port (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sck(sck),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .wr_stb(wr_stb),
        .rd_load(),
        .rd_data(rd_data)
    );

    // one decode serves both the write path and the read mux
    function [5:0] reg_select;
        input [5:0] a;
        begin
            reg_select = 6'h00;
            case (a)
                `ADDR_RECEIVE_FILTER_CONTROL: reg_select = 6'h01;
                `ADDR_RF_PLL_CONTROL: reg_select = 6'h02;
                `ADDR_TX_POWER_CONTROL: reg_select = 6'h04;
                `ADDR_TX_FILTER_BATTERY_CONTROL: reg_select = 6'h08;
                `ADDR_VCO_REFCLK_CONTROL: reg_select = 6'h10;
                `ADDR_CCA_RSSI_THRESHOLD: reg_select = 6'h20;
                default: reg_select = 6'h00;
            endcase
        end
    endfunction

    wire [5:0] wr_sel;
    wire [5:0] rd_sel;
    assign wr_sel = wr_stb ? reg_select(reg_addr) : 6'h00;
    assign rd_sel = reg_select(reg_addr);

    // reserved bits are kept as written; software is expected to leave them zero
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            receive_filter_control <= `REG_RESET_VALUE;
            rf_pll_control <= `REG_RESET_VALUE;
            tx_power_control <= `REG_RESET_VALUE;
            tx_filter_battery_control <= `REG_RESET_VALUE;
            vco_refclk_control <= `REG_RESET_VALUE;
            cca_rssi_threshold <= `REG_RESET_VALUE;
        end else begin
            if (wr_sel[0]) begin
                receive_filter_control <= wr_data & `MASK_RECEIVE_FILTER_CONTROL;
            end
            if (wr_sel[1]) begin
                rf_pll_control <= wr_data & `MASK_RF_PLL_CONTROL;
            end
            if (wr_sel[2]) begin
                tx_power_control <= wr_data & `MASK_TX_POWER_CONTROL;
            end
            if (wr_sel[3]) begin
                tx_filter_battery_control <= wr_data & `MASK_TX_FILTER_BATTERY_CONTROL;
            end
            if (wr_sel[4]) begin
                vco_refclk_control <= wr_data & `MASK_VCO_REFCLK_CONTROL;
            end
            if (wr_sel[5]) begin
                cca_rssi_threshold <= wr_data & `MASK_CCA_RSSI_THRESHOLD;
            end
        end
    end

    // unmapped addresses read as zero
    always @* begin
        rd_data = 8'h00;
        case (rd_sel)
            6'h01: rd_data = receive_filter_control;
            6'h02: rd_data = rf_pll_control;
            6'h04: rd_data = tx_power_control;
            6'h08: rd_data = tx_filter_battery_control;
            6'h10: rd_data = vco_refclk_control;
            6'h20: rd_data = cca_rssi_threshold;
            default: rd_data = 8'h00;
        endcase
    end

    // configuration outputs mirror the fields one cycle after the write
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            synth_lock_enable <= 1'b0;
            tx_attenuation_code <= 5'h00;
            tx_shaping_filter <= 1'b0;
            supply_monitor_on <= 1'b0;
            oscillator_boost <= 1'b0;
            refclk_early_stabilize <= 1'b0;
            network_leader_role <= 1'b0;
            parent_role <= 1'b0;
        end else begin
            synth_lock_enable <= rf_pll_control[`BIT_SYNTH_LOCK_ENABLE];
            tx_attenuation_code <= tx_power_control[`MSB_TX_ATTENUATION_CODE:`LSB_TX_ATTENUATION_CODE];
            tx_shaping_filter <= tx_filter_battery_control[`BIT_TX_SHAPING_FILTER];
            supply_monitor_on <= tx_filter_battery_control[`BIT_SUPPLY_MONITOR_ON];
            oscillator_boost <= vco_refclk_control[`BIT_OSCILLATOR_BOOST];
            refclk_early_stabilize <= vco_refclk_control[`BIT_REFCLK_EARLY_STABILIZE];
            network_leader_role <= receive_filter_control[`BIT_NETWORK_LEADER_ROLE];
            parent_role <= receive_filter_control[`BIT_PARENT_ROLE];
        end
    end

    // transmit: pass bytes, then two fcs bytes low first unless suppressed
    assign tx_take = tx_ready & tx_valid;

    fcs16 u_tx_fcs (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(tx_take & tx_last),
        .valid(tx_take & ~tx_last),
        .data(tx_data),
        .crc(tx_crc)
    );

    always @* begin
        next_tx_state = tx_state;
        case (tx_state)
            ST_DATA: begin
                if (tx_take && tx_last && !receive_filter_control[`BIT_TX_CHECKSUM_SUPPRESS]) begin
                    next_tx_state = ST_FCS_LO;
                end
            end
            ST_FCS_LO: next_tx_state = ST_FCS_HI;
            ST_FCS_HI: next_tx_state = ST_DATA;
            default: next_tx_state = ST_DATA;
        endcase
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= ST_DATA;
            tx_ready <= 1'b0;
            phy_tx_data <= 8'h00;
            phy_tx_valid <= 1'b0;
            phy_tx_last <= 1'b0;
            fcs_hold <= `FCS_INIT;
        end else begin
            tx_state <= next_tx_state;
            // no transmit while the pll is off
            tx_ready <= (next_tx_state == ST_DATA) & rf_pll_control[`BIT_SYNTH_LOCK_ENABLE];
            phy_tx_valid <= 1'b0;
            phy_tx_last <= 1'b0;
            case (tx_state)
                ST_DATA: begin
                    if (tx_take) begin
                        phy_tx_data <= tx_data;
                        phy_tx_valid <= 1'b1;
                        phy_tx_last <= tx_last & receive_filter_control[`BIT_TX_CHECKSUM_SUPPRESS];
                        if (tx_last) begin
                            fcs_hold <= fcs16_final(tx_crc, tx_data);
                        end
                    end
                end
                ST_FCS_LO: begin
                    phy_tx_data <= fcs_hold[7:0];
                    phy_tx_valid <= 1'b1;
                end
                ST_FCS_HI: begin
                    phy_tx_data <= fcs_hold[15:8];
                    phy_tx_valid <= 1'b1;
                    phy_tx_last <= 1'b1;
                end
                default: begin
                    phy_tx_valid <= 1'b0;
                end
            endcase
        end
    end

    // folds the last byte in, since the accumulator is cleared by that same byte
    function [15:0] fcs16_final;
        input [15:0] c;
        input [7:0] d;
        integer i;
        reg [15:0] t;
        begin
            t = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (t[0] ^ d[i]) begin
                    t = (t >> 1) ^ `FCS_POLY_REFLECTED;
                end else begin
                    t = t >> 1;
                end
            end
            fcs16_final = t;
        end
    endfunction

    // receive: the sum over payload and fcs leaves a zero residue when intact
    fcs16 u_rx_fcs (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(rx_end),
        .valid(rx_valid),
        .data(rx_data),
        .crc(rx_crc)
    );

    assign rx_fcs_good = (rx_crc == `FCS_RESIDUE);
    assign filter_miss = rx_mac_addr_mismatch | rx_illegal_frame_type | rx_pan_mismatch | rx_short_addr_mismatch;
    // a bad-fcs frame taken by the error-report mode skips the address filter only when promiscuous
    assign rx_keep = rf_pll_control[`BIT_SYNTH_LOCK_ENABLE]
                   & (rx_fcs_good | receive_filter_control[`BIT_ACCEPT_BAD_CHECKSUM])
                   & (receive_filter_control[`BIT_ACCEPT_ALL_FRAMES] | ~filter_miss);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_frame_accept <= 1'b0;
            rx_frame_drop <= 1'b0;
            rx_crc_ok <= 1'b0;
            ack_send <= 1'b0;
        end else begin
            rx_frame_accept <= rx_end & rx_keep;
            rx_frame_drop <= rx_end & ~rx_keep;
            if (rx_end) begin
                rx_crc_ok <= rx_fcs_good;
            end
            // never acknowledge a corrupted frame even when it is kept
            ack_send <= rx_end & rx_keep & rx_fcs_good & rx_ack_request
                      & ~receive_filter_control[`BIT_AUTO_REPLY_SUPPRESS];
        end
    end

    // clear channel assessment compare
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cca_done <= 1'b0;
            cca_fail <= 1'b0;
        end else begin
            cca_done <= cca_rssi_valid;
            if (cca_rssi_valid) begin
                cca_fail <= (cca_rssi < cca_rssi_threshold);
            end
        end
    end

endmodule // rx_filter_phy_config_regs

/* rx_filter_phy_config_regs_assertions.sv */
// port-level checker for the configuration register bank and the logic it steers
// assumes binding into rx_filter_phy_config_regs; single ref_clk domain
`timescale 1ns/1ps
module rx_filter_phy_config_regs_checker (
    input wire ref_clk,
    input wire nrst,
    input wire cs_n,
    input wire sdo_oe,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_last,
    input wire tx_ready,
    input wire [7:0] phy_tx_data,
    input wire phy_tx_valid,
    input wire phy_tx_last,
    input wire rx_end,
    input wire rx_ack_request,
    input wire rx_frame_accept,
    input wire rx_frame_drop,
    input wire rx_crc_ok,
    input wire ack_send,
    input wire [7:0] cca_rssi,
    input wire cca_rssi_valid,
    input wire cca_done,
    input wire cca_fail,
    input wire synth_lock_enable,
    input wire [4:0] tx_attenuation_code,
    input wire network_leader_role,
    input wire parent_role
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_ack_needs_request: assert property (
        ack_send |-> $past(rx_end && rx_ack_request) && rx_crc_ok && rx_frame_accept)
        else $error("ack sent without a good requested frame");
    a_drop_no_ack: assert property (
        rx_frame_drop |-> !ack_send && !rx_frame_accept) else $error("ack or accept with a drop");
    a_rx_one_verdict: assert property (
        rx_end |=> rx_frame_accept != rx_frame_drop) else $error("frame verdict missing or doubled");
    a_pll_off_drop: assert property (
        rx_end && !synth_lock_enable |=> rx_frame_drop && !ack_send) else $error("frame kept with pll off");
    a_cca_done_lat: assert property (
        cca_rssi_valid |=> cca_done) else $error("cca result late");
    a_cca_top_pass: assert property (
        cca_rssi_valid && cca_rssi == 8'hff |=> !cca_fail) else $error("cca failed at full rssi");
    a_tx_byte_forward: assert property (
        tx_valid && tx_ready |=> phy_tx_valid && phy_tx_data == $past(tx_data))
        else $error("transmit byte not forwarded");
    a_tx_frame_end: assert property (
        tx_valid && tx_ready && tx_last |=> phy_tx_last or (!phy_tx_last ##2 phy_tx_last))
        else $error("frame end misplaced");
    a_reset_clear: assert property (
        $rose(nrst) |-> !synth_lock_enable && tx_attenuation_code == 5'h00 && !network_leader_role
            && !parent_role && !tx_ready) else $error("output not clear after reset");
    a_sdo_enable_follow: assert property (
        sdo_oe == $past(!cs_n)) else $error("sdo enable not following select");
endmodule // rx_filter_phy_config_regs_checker
bind rx_filter_phy_config_regs rx_filter_phy_config_regs_checker i_chk (.*);

/* rx_filter_phy_config_regs_bench.sv */
// self-checking bench: register access, transmit fcs, receive filter, cca compare
// assumes spi_host_model as the host; the radio side is driven here directly
`timescale 1ns/1ps
module rx_filter_phy_config_regs_bench;
    logic ref_clk, nrst, tx_valid, tx_last, rx_valid, rx_end, rx_ack_request, cca_rssi_valid;
    logic rx_mac_addr_mismatch, rx_illegal_frame_type, rx_pan_mismatch, rx_short_addr_mismatch;
    logic [7:0] tx_data, rx_data, cca_rssi;
    wire sck, cs_n, sdi, sdo, sdo_oe, tx_ready, phy_tx_valid, phy_tx_last, rx_frame_accept;
    wire rx_frame_drop, rx_crc_ok, ack_send, cca_done, cca_fail, synth_lock_enable, tx_shaping_filter;
    wire supply_monitor_on, oscillator_boost, refclk_early_stabilize, network_leader_role, parent_role;
    wire [7:0] phy_tx_data;
    wire [4:0] tx_attenuation_code;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [8:0] txq[$];
    rx_filter_phy_config_regs i_dut (.*);
    spi_host_model i_host (.ref_clk(ref_clk), .sdo(sdo), .sck(sck), .cs_n(cs_n), .sdi(sdi));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (phy_tx_valid === 1'b1)
            txq.push_back({phy_tx_last, phy_tx_data});
        if (cycles == 40000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // address 0 also loses its reserved bits, which the host always clears
    function automatic logic [7:0] rd_mask(input logic [5:0] a);
        case (a)
            6'h00: rd_mask = 8'haf;
            6'h01, 6'h02: rd_mask = 8'hf8;
            6'h03: rd_mask = 8'hb8;
            6'h04: rd_mask = 8'h11;
            6'h05: rd_mask = 8'hff;
            default: rd_mask = 8'h00;
        endcase
    endfunction
    function automatic logic [15:0] fcs(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (b[i])
            for (int k = 0; k < 8; k++)
                c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        return c;
    endfunction
    task automatic chk_cfg(input logic [5:0] a, input logic [7:0] d);
        case (a)
            6'h00: begin
                chk_flag(network_leader_role, d[3]);
                chk_flag(parent_role, d[2]);
            end
            6'h01: chk_flag(synth_lock_enable, d[7]);
            6'h02: chk_byte({3'h0, tx_attenuation_code}, {3'h0, d[7:3]});
            6'h03: begin
                chk_flag(tx_shaping_filter, d[7]);
                chk_flag(supply_monitor_on, d[3]);
            end
            6'h04: begin
                chk_flag(oscillator_boost, d[4]);
                chk_flag(refclk_early_stabilize, d[0]);
            end
            default: ;
        endcase
    endtask
    task automatic cca(input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        cca_rssi = v;
        cca_rssi_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        cca_rssi_valid = 1'b0;
    endtask
    task automatic send_tx(input logic [7:0] b[$]);
        int t;
        foreach (b[i]) begin
            tx_data = b[i];
            tx_valid = 1'b1;
            tx_last = (i == b.size() - 1);
            t = 0;
            do begin
                @(posedge ref_clk);
                t++;
            end while (tx_ready !== 1'b1 && t < 50);
            if (tx_ready !== 1'b1)
                mismatches++;
            #1;
        end
        tx_valid = 1'b0;
        tx_last = 1'b0;
    endtask
    task automatic send_rx(input logic [7:0] b[$], input logic req, input logic [3:0] mm, output logic [3:0] r);
        foreach (b[i]) begin
            rx_data = b[i];
            rx_valid = 1'b1;
            @(posedge ref_clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_end = 1'b1;
        rx_ack_request = req;
        {rx_mac_addr_mismatch, rx_illegal_frame_type, rx_pan_mismatch, rx_short_addr_mismatch} = mm;
        @(posedge ref_clk);
        #1;
        rx_end = 1'b0;
        r = {rx_frame_accept, rx_frame_drop, rx_crc_ok, ack_send};
    endtask
    initial begin
        logic [7:0] d, v, b[$];
        logic [15:0] c;
        logic [3:0] r, mm;
        logic keep;
        int n;
        {tx_valid, tx_last, rx_valid, rx_end, rx_ack_request, cca_rssi_valid} = 6'h00;
        {rx_mac_addr_mismatch, rx_illegal_frame_type, rx_pan_mismatch, rx_short_addr_mismatch} = 4'h0;
        tx_data = 8'h00;
        rx_data = 8'h00;
        cca_rssi = 8'h00;
        nrst = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        n = $urandom(9593);
        for (int a = 0; a < 7; a++) begin
            i_host.rd(6'(a), v);
            chk_byte(v, 8'h00);
        end
        chk_flag(tx_ready, 1'b0);
        $display("test reset done");
        // first pass runs on the reset threshold of zero
        for (int j = 0; j < 4; j++) begin
            d = (j == 0) ? 8'h00 : 8'($urandom);
            if (j > 0)
                i_host.wr(6'h05, d);
            for (int q = 0; q < 4; q++) begin
                v = (q == 0) ? d - 8'h01 : (q == 1) ? d : 8'($urandom);
                cca(v);
                chk_flag(cca_done, 1'b1);
                chk_flag(cca_fail, v < d);
            end
        end
        $display("test cca done");
        for (int k = 0; k < 28; k++) begin
            d = (k < 7) ? 8'hff : 8'($urandom);
            i_host.wr(6'(k % 7), d);
            i_host.rd(6'(k % 7), v);
            chk_byte(v, d & rd_mask(6'(k % 7)));
            chk_cfg(6'(k % 7), d);
        end
        i_host.xfer(8'h80, 8'h00, v);
        chk_byte(v, 8'h00);
        $display("test registers done");
        i_host.setup();
        for (int s = 0; s < 4; s++) begin
            i_host.wr(6'h00, {s[0], 7'h00});
            b.delete();
            n = (s < 2) ? 1 : 2 + $urandom % 8;
            repeat (n) b.push_back(8'($urandom));
            txq.delete();
            send_tx(b);
            repeat (6) @(posedge ref_clk);
            c = fcs(b);
            if (s[0] == 1'b0) begin
                b.push_back(c[7:0]);
                b.push_back(c[15:8]);
            end
            chk_byte(8'(txq.size()), 8'(b.size()));
            foreach (b[i]) begin
                chk_byte(txq[i][7:0], b[i]);
                chk_flag(txq[i][8], i == b.size() - 1);
            end
        end
        $display("test transmit done");
        for (int m = 0; m < 32; m++) begin
            i_host.wr(6'h00, {2'b00, m[0], 3'b000, m[1], m[2]});
            b.delete();
            repeat (3 + $urandom % 4) b.push_back(8'($urandom));
            c = fcs(b);
            b.push_back(c[7:0]);
            b.push_back(c[15:8] ^ {7'h00, ~m[3]});
            mm = ($urandom % 2) ? 4'h0 : 4'(1 << ($urandom % 4));
            send_rx(b, m[4], mm, r);
            keep = (m[3] | m[1]) & (m[2] | (mm == 4'h0));
            chk_byte({4'h0, r}, {4'h0, keep, ~keep, m[3], keep & m[3] & m[4] & ~m[0]});
        end
        i_host.wr(6'h01, 8'h00);
        chk_flag(tx_ready, 1'b0);
        send_rx(b, 1'b1, 4'h0, r);
        chk_byte({4'h0, r}, 8'h06);
        $display("test receive done");
        final_report();
    end
endmodule // rx_filter_phy_config_regs_bench

/* rx_filter_phy_consts.vh */
// constants for the receive-filter and phy configuration register bank
// assumes a short-address serial register port with 6-bit register addresses
`ifndef RX_FILTER_PHY_CONSTS_VH
`define RX_FILTER_PHY_CONSTS_VH

// register addresses in the short address space
`define ADDR_RECEIVE_FILTER_CONTROL 6'h00
`define ADDR_RF_PLL_CONTROL 6'h01
`define ADDR_TX_POWER_CONTROL 6'h02
`define ADDR_TX_FILTER_BATTERY_CONTROL 6'h03
`define ADDR_VCO_REFCLK_CONTROL 6'h04
`define ADDR_CCA_RSSI_THRESHOLD 6'h05

// receive_filter_control fields
`define BIT_TX_CHECKSUM_SUPPRESS 7
`define BIT_AUTO_REPLY_SUPPRESS 5
`define BIT_NETWORK_LEADER_ROLE 3
`define BIT_PARENT_ROLE 2
`define BIT_ACCEPT_BAD_CHECKSUM 1
`define BIT_ACCEPT_ALL_FRAMES 0

// other fields
`define BIT_SYNTH_LOCK_ENABLE 7
`define MSB_TX_ATTENUATION_CODE 7
`define LSB_TX_ATTENUATION_CODE 3
`define BIT_TX_SHAPING_FILTER 7
`define BIT_SUPPLY_MONITOR_ON 3
`define BIT_OSCILLATOR_BOOST 4
`define BIT_REFCLK_EARLY_STABILIZE 0

// implemented bit masks; reserved bits are stored, unimplemented read zero
`define MASK_RECEIVE_FILTER_CONTROL 8'hff
`define MASK_RF_PLL_CONTROL 8'hf8
`define MASK_TX_POWER_CONTROL 8'hf8
`define MASK_TX_FILTER_BATTERY_CONTROL 8'hb8
`define MASK_VCO_REFCLK_CONTROL 8'h11
`define MASK_CCA_RSSI_THRESHOLD 8'hff

`define REG_RESET_VALUE 8'h00

// frame check sequence: reflected ccitt polynomial, zero start value
`define FCS_POLY_REFLECTED 16'h8408
`define FCS_INIT 16'h0000
`define FCS_RESIDUE 16'h0000

// serial transfer
`define SPI_HEADER_LAST 4'h7
`define SPI_DATA_LAST 4'hf

`endif

/* spi_host_model.sv */
// host controller model: short-address register writes and reads over spi, mode 0, msb first
// assumes ref_clk is the device clock; every sck level lasts 3 ref_clk cycles
`timescale 1ns/1ps
module spi_host_model (
    input wire ref_clk,
    input wire sdo,
    output logic sck,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // one 16-bit frame; the answer bit is taken at the edge that raises sck
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] dat, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {hdr, dat};
        rd = 8'h00;
        @(posedge ref_clk);
        #1;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            repeat (3) @(posedge ref_clk);
            if (i < 8)
                rd = {rd[6:0], sdo};
            #1;
            sck = 1'b1;
            repeat (3) @(posedge ref_clk);
            #1;
            sck = 1'b0;
        end
        repeat (3) @(posedge ref_clk);
        #1;
        cs_n = 1'b1;
        // a released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        if (a == 6'h00)
            d = d & 8'haf;
        xfer({1'b0, a, 1'b1}, d, x);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        xfer({1'b0, a, 1'b0}, 8'h00, v);
    endtask
    // radio work needs the synthesiser; shaping filter set as advised
    task automatic setup;
        wr(6'h01, 8'h80);
        wr(6'h03, 8'h80);
    endtask
endmodule // spi_host_model

/* spi_short_port.v */
// serial register port, short address space, mode 0, msb first
// assumes sck is sampled on ref_clk and each sck level lasts at least 2 ref_clk cycles
`timescale 1ns/1ps
`include "rx_filter_phy_consts.vh"

module spi_short_port (
    input wire ref_clk,
    input wire nrst,
    input wire sck,
    input wire cs_n,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    output reg [5:0] reg_addr,
    output reg [7:0] wr_data,
    output reg wr_stb,
    output reg rd_load,
    input wire [7:0] rd_data
);

    reg sck_q;
    reg [3:0] bit_cnt;
    reg [7:0] shift_in;
    reg [7:0] shift_out;
    reg is_write;
    reg is_long;
    reg load_pend;
    wire sck_rise;
    wire sck_fall;

    assign sck_rise = sck & ~sck_q;
    assign sck_fall = ~sck & sck_q;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sck_q <= 1'b0;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            is_write <= 1'b0;
            is_long <= 1'b0;
            load_pend <= 1'b0;
            reg_addr <= 6'h00;
            wr_data <= 8'h00;
            wr_stb <= 1'b0;
            rd_load <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sck_q <= sck;
            wr_stb <= 1'b0;
            rd_load <= 1'b0;
            sdo_oe <= ~cs_n;
            if (load_pend) begin
                shift_out <= rd_data;
                load_pend <= 1'b0;
            end
            if (cs_n) begin
                bit_cnt <= 4'h0;
                sdo <= 1'b0;
            end else if (sck_rise) begin
                shift_in <= {shift_in[6:0], sdi};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == `SPI_HEADER_LAST) begin
                    // header: long-flag, six address bits, write flag
                    is_long <= shift_in[6];
                    is_write <= sdi;
                    reg_addr <= shift_in[5:0];
                    if (!sdi && !shift_in[6]) begin
                        rd_load <= 1'b1;
                        load_pend <= 1'b1;
                    end
                end else if (bit_cnt == `SPI_DATA_LAST) begin
                    // long-address transfers are not served by this bank
                    if (is_write && !is_long) begin
                        wr_data <= {shift_in[6:0], sdi};
                        wr_stb <= 1'b1;
                    end
                end
            end else if (sck_fall && bit_cnt[3] && !is_write && !is_long) begin
                sdo <= shift_out[7];
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

endmodule // spi_short_port
